// File: hdl/adc_seq_pkg.sv
package adc_seq_pkg;

    // Register bus
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_RESULT    = 8'h08;
    localparam logic [7:0]  REG_MUXSEL    = 8'h0C;
    localparam logic [7:0]  REG_PERIOD    = 8'h10;
    localparam logic [7:0]  REG_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  REG_IRQ_MASK  = 8'h18;

    // Control register fields
    localparam int          CTRL_START_BIT = 0;
    localparam int          CTRL_STOP_BIT  = 1;
    localparam int          CTRL_MODE_LSB  = 2;
    localparam int          MODE_W         = 2;

    // Status register fields
    localparam int          STAT_DONE_BIT  = 0;
    localparam int          STAT_BUSY_BIT  = 1;
    localparam int          STAT_VALID_BIT = 2;
    localparam int          STAT_HOLD_BIT  = 3;

    // Interrupt status and mask fields
    localparam int          IRQ_W          = 2;
    localparam int          IRQ_DONE_BIT   = 0;
    localparam int          IRQ_OVR_BIT    = 1;

    // Conversion sequencing
    typedef enum logic [1:0] {MODE_SINGLE, MODE_CONT, MODE_MULTI, MODE_RSVD} mode_e;
    typedef enum logic [1:0] {ST_STANDBY, ST_RUN, ST_HOLD} seq_e;

    localparam int          PRIME_W        = 3;
    localparam logic [2:0]  PRIME_CONVS    = 3'h3;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          CONV_TIME_NS   = 5000;
    localparam int          CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int          PERIOD_W       = 16;
    localparam int          MUX_W          = 4;
    localparam int          RES_W          = 16;

endpackage

// File: hdl/adc_conversion_sequencer.sv
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
// Function
// - In single mode the sequencer idles in standby until a trigger, then runs four conversions back to back.
// - The first three conversions only prime the decimator; the result and end-of-conversion follow the fourth.
// - After the single result is read out the sequencer returns to standby until the next trigger.
// - Completion shows in a pollable status bit and on the end-of-conversion output for interrupt or DMA.
// - In continuous mode the first result follows three priming conversions, then one result per period.
// - In multi mode the decimator is cleared and re-primed between samples.
// - In multi mode each finished sample starts the next one without a new trigger.
// - A start-of-conversion input begins a conversion and may come from a clock or programmable logic.
// - The start-of-conversion input is optional; continuous mode runs from the software start alone.
// - End-of-conversion rises at the completion of every conversion that yields a result.
// - Every mode starts from either a software start bit or the start-of-conversion input.
// - End-of-conversion and the done status bit stay high until the result is read.
// - After the input channel changes, no result is valid until the fourth following conversion ends.
module adc_conversion_sequencer #(
    parameter int RES_W    = adc_seq_pkg::RES_W,
    parameter int MUX_W    = adc_seq_pkg::MUX_W,
    parameter int PERIOD_W = adc_seq_pkg::PERIOD_W
) (
    input  wire logic                           sys_clk_i,
    input  wire logic                           srst_i,
    input  wire logic [adc_seq_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [adc_seq_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                           wr_i,
    input  wire logic                           rd_i,
    output logic      [adc_seq_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                           soc_i,
    input  wire logic [RES_W-1:0]               dec_data_i,
    output logic                                mod_run_o,
    output logic                                decim_clr_o,
    output logic      [MUX_W-1:0]               mux_sel_o,
    output logic                                eoc_o,
    output logic                                irq_o
);

    localparam logic [PERIOD_W-1:0] PERIOD_RST = PERIOD_W'(adc_seq_pkg::CONV_CYCLES);
    localparam logic [PERIOD_W-1:0] ONE_TICK   = PERIOD_W'(1);

    logic                         soc_meta;
    logic                         soc_sync;
    logic                         soc_prev;
    logic                         soc_rise;
    adc_seq_pkg::mode_e           mode;
    adc_seq_pkg::seq_e            state;
    logic [PERIOD_W-1:0]          conv_len;
    logic [PERIOD_W-1:0]          tick_cnt;
    logic [adc_seq_pkg::PRIME_W-1:0] prime_cnt;
    logic [RES_W-1:0]             result;
    logic                         done;
    logic [adc_seq_pkg::IRQ_W-1:0] irq_stat;
    logic [adc_seq_pkg::IRQ_W-1:0] irq_mask;
    logic [adc_seq_pkg::IRQ_W-1:0] irq_evt;
    logic                         wr_ctrl;
    logic                         sw_start;
    logic                         sw_stop;
    logic                         mux_chg;
    logic                         rd_res;
    logic                         trig;
    logic                         conv_done;
    logic                         primed;
    logic                         result_ready;
    logic                         start_seq;

    // Start-of-conversion pin synchroniser and edge detect
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            soc_meta <= 1'b0;
            soc_sync <= 1'b0;
            soc_prev <= 1'b0;
        end else begin
            soc_meta <= soc_i;
            soc_sync <= soc_meta;
            soc_prev <= soc_sync;
        end
    end

    assign soc_rise  = soc_sync & ~soc_prev;

    // Bus decode
    assign wr_ctrl   = wr_i && (addr_i == adc_seq_pkg::REG_CTRL);
    assign sw_start  = wr_ctrl && wdata_i[adc_seq_pkg::CTRL_START_BIT];
    assign sw_stop   = wr_ctrl && wdata_i[adc_seq_pkg::CTRL_STOP_BIT];
    assign mux_chg   = wr_i && (addr_i == adc_seq_pkg::REG_MUXSEL) && (wdata_i[MUX_W-1:0] != mux_sel_o);
    assign rd_res    = rd_i && (addr_i == adc_seq_pkg::REG_RESULT);

    assign trig      = sw_start | soc_rise;
    assign start_seq = (state == adc_seq_pkg::ST_STANDBY) && trig && !sw_stop;
    assign conv_done = (state == adc_seq_pkg::ST_RUN) && (tick_cnt <= ONE_TICK);
    assign primed    = (prime_cnt == adc_seq_pkg::PRIME_CONVS);
    assign result_ready = conv_done && primed && !mux_chg;

    // Configuration registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mode      <= adc_seq_pkg::MODE_SINGLE;
            conv_len  <= PERIOD_RST;
            mux_sel_o <= '0;
            irq_mask  <= '0;
        end else if (wr_i) begin
            case (addr_i)
                adc_seq_pkg::REG_CTRL: begin
                    if (state == adc_seq_pkg::ST_STANDBY) begin
                        mode <= adc_seq_pkg::mode_e'(wdata_i[adc_seq_pkg::CTRL_MODE_LSB +: adc_seq_pkg::MODE_W]);
                    end
                end
                adc_seq_pkg::REG_PERIOD:   conv_len  <= wdata_i[PERIOD_W-1:0];
                adc_seq_pkg::REG_MUXSEL:   mux_sel_o <= wdata_i[MUX_W-1:0];
                adc_seq_pkg::REG_IRQ_MASK: irq_mask  <= wdata_i[adc_seq_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Sequencer state
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state <= adc_seq_pkg::ST_STANDBY;
        end else if (sw_stop) begin
            state <= adc_seq_pkg::ST_STANDBY;
        end else begin
            case (state)
                adc_seq_pkg::ST_STANDBY: begin
                    if (start_seq) begin
                        state <= adc_seq_pkg::ST_RUN;
                    end
                end
                adc_seq_pkg::ST_RUN: begin
                    if (result_ready && (mode != adc_seq_pkg::MODE_CONT) && (mode != adc_seq_pkg::MODE_MULTI)) begin
                        state <= adc_seq_pkg::ST_HOLD;
                    end
                end
                adc_seq_pkg::ST_HOLD: begin
                    if (rd_res) begin
                        state <= adc_seq_pkg::ST_STANDBY;
                    end
                end
                default: state <= adc_seq_pkg::ST_STANDBY;
            endcase
        end
    end

    // Conversion period divider
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tick_cnt <= PERIOD_RST;
        end else if (start_seq || conv_done) begin
            tick_cnt <= conv_len;
        end else if (state == adc_seq_pkg::ST_RUN) begin
            tick_cnt <= tick_cnt - ONE_TICK;
        end
    end

    // Decimator priming count
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            prime_cnt <= '0;
        end else if (start_seq || mux_chg) begin
            prime_cnt <= '0;
        end else if (result_ready && (mode == adc_seq_pkg::MODE_MULTI)) begin
            prime_cnt <= '0;
        end else if (conv_done && !primed) begin
            prime_cnt <= prime_cnt + adc_seq_pkg::PRIME_W'(1);
        end
    end

    // Decimator clear pulse at every start and between multi samples
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            decim_clr_o <= 1'b0;
        end else begin
            decim_clr_o <= start_seq || (result_ready && (mode == adc_seq_pkg::MODE_MULTI));
        end
    end

    assign mod_run_o = (state == adc_seq_pkg::ST_RUN);

    // Result capture and completion flag
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            result <= '0;
        end else if (result_ready) begin
            result <= dec_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            done <= 1'b0;
        end else if (result_ready) begin
            done <= 1'b1;
        end else if (rd_res) begin
            done <= 1'b0;
        end
    end

    assign eoc_o = done;

    // Interrupt status, write one to clear, set wins
    assign irq_evt[adc_seq_pkg::IRQ_DONE_BIT] = result_ready;
    assign irq_evt[adc_seq_pkg::IRQ_OVR_BIT]  = result_ready && done && !rd_res;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_stat <= '0;
        end else if (wr_i && (addr_i == adc_seq_pkg::REG_IRQ_STAT)) begin
            irq_stat <= (irq_stat & ~wdata_i[adc_seq_pkg::IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat <= irq_stat | irq_evt;
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    // Read data, one cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= '0;
            case (addr_i)
                adc_seq_pkg::REG_CTRL: begin
                    rdata_o[adc_seq_pkg::CTRL_MODE_LSB +: adc_seq_pkg::MODE_W] <= mode;
                end
                adc_seq_pkg::REG_STATUS: begin
                    rdata_o[adc_seq_pkg::STAT_DONE_BIT]  <= done;
                    rdata_o[adc_seq_pkg::STAT_BUSY_BIT]  <= mod_run_o;
                    rdata_o[adc_seq_pkg::STAT_VALID_BIT] <= primed;
                    rdata_o[adc_seq_pkg::STAT_HOLD_BIT]  <= (state == adc_seq_pkg::ST_HOLD);
                end
                adc_seq_pkg::REG_RESULT:   rdata_o[RES_W-1:0]    <= result;
                adc_seq_pkg::REG_MUXSEL:   rdata_o[MUX_W-1:0]    <= mux_sel_o;
                adc_seq_pkg::REG_PERIOD:   rdata_o[PERIOD_W-1:0] <= conv_len;
                adc_seq_pkg::REG_IRQ_STAT: rdata_o[adc_seq_pkg::IRQ_W-1:0] <= irq_stat;
                adc_seq_pkg::REG_IRQ_MASK: rdata_o[adc_seq_pkg::IRQ_W-1:0] <= irq_mask;
                default: begin
                end
            endcase
        end
    end

    // Conversions since the last priming restart, for checking only
    logic [3:0] conv_seen;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            conv_seen <= '0;
        end else if (start_seq || mux_chg || (result_ready && (mode == adc_seq_pkg::MODE_MULTI))) begin
            conv_seen <= '0;
        end else if (conv_done && (conv_seen != 4'hF)) begin
            conv_seen <= conv_seen + 4'h1;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    chk_four_convs: assert property (
        result_ready && (mode != adc_seq_pkg::MODE_CONT) |-> conv_seen == 4'h3)
        else $error("result not on fourth conversion");

    chk_start_runs: assert property (
        (state == adc_seq_pkg::ST_STANDBY) && trig && !sw_stop
        |=> (state == adc_seq_pkg::ST_RUN) && decim_clr_o && (prime_cnt == '0))
        else $error("trigger did not start a sequence");

    chk_hold_ignores: assert property (
        (state == adc_seq_pkg::ST_HOLD) && !rd_res && !sw_stop |=> (state == adc_seq_pkg::ST_HOLD) && !decim_clr_o)
        else $error("single sequence restarted early");

    chk_standby_return: assert property (
        (state == adc_seq_pkg::ST_HOLD) && rd_res |=> (state == adc_seq_pkg::ST_STANDBY) && !eoc_o)
        else $error("no return to standby after read");

    chk_eoc_rise: assert property (
        result_ready |=> eoc_o && (result == $past(dec_data_i)))
        else $error("end of conversion missing");

    chk_eoc_hold: assert property (
        eoc_o && !rd_res |=> eoc_o)
        else $error("end of conversion dropped before read");

    chk_cont_rate: assert property (
        conv_done && (mode == adc_seq_pkg::MODE_CONT) && !sw_stop |=> tick_cnt == $past(conv_len))
        else $error("continuous period not reloaded");

    chk_multi_restart: assert property (
        result_ready && (mode == adc_seq_pkg::MODE_MULTI) && !sw_stop
        |=> decim_clr_o && (state == adc_seq_pkg::ST_RUN) && (prime_cnt == '0))
        else $error("multi sample not re-primed");

    chk_mux_invalid: assert property (
        mux_chg |=> !primed [*3])
        else $error("result valid too soon after channel change");

    chk_irq_done: assert property (
        result_ready && irq_mask[adc_seq_pkg::IRQ_DONE_BIT] |=> irq_o && done)
        else $error("done interrupt not raised");

    chk_single_standby: assert property (
        (state == adc_seq_pkg::ST_STANDBY) && !trig |=> (state == adc_seq_pkg::ST_STANDBY))
        else $error("left standby without a trigger");

    chk_cont_no_clear: assert property (
        (state == adc_seq_pkg::ST_RUN) && (mode == adc_seq_pkg::MODE_CONT) |=> !decim_clr_o)
        else $error("continuous mode re-primed");

    chk_cont_stays: assert property (
        (state == adc_seq_pkg::ST_RUN) && (mode == adc_seq_pkg::MODE_CONT) && !sw_stop
        |=> (state == adc_seq_pkg::ST_RUN))
        else $error("continuous mode stopped on its own");

    chk_mode_locked: assert property (
        (state != adc_seq_pkg::ST_STANDBY) |=> (mode == $past(mode)))
        else $error("mode changed during a sequence");

    chk_eoc_read: assert property (
        eoc_o && rd_res && !result_ready |=> !eoc_o)
        else $error("end of conversion kept after read");

    chk_overrun_flag: assert property (
        result_ready && done && !rd_res |=> irq_stat[adc_seq_pkg::IRQ_OVR_BIT])
        else $error("overrun not flagged");

    chk_irq_clear: assert property (
        wr_i && (addr_i == adc_seq_pkg::REG_IRQ_STAT) && wdata_i[adc_seq_pkg::IRQ_DONE_BIT] && !result_ready
        |=> !irq_stat[adc_seq_pkg::IRQ_DONE_BIT])
        else $error("done status not cleared by write");

    chk_stop_wins: assert property (
        sw_stop |=> (state == adc_seq_pkg::ST_STANDBY))
        else $error("stop bit did not force standby");

    cov_single: cover property (
        (mode == adc_seq_pkg::MODE_SINGLE) && result_ready ##[1:20] rd_res);
    cov_cont_two: cover property (
        (mode == adc_seq_pkg::MODE_CONT) && result_ready ##[1:1000] result_ready);
    cov_multi: cover property (
        (mode == adc_seq_pkg::MODE_MULTI) && result_ready ##1 decim_clr_o);
    cov_overrun: cover property (
        irq_evt[adc_seq_pkg::IRQ_OVR_BIT]);
    cov_mux_change: cover property (
        mux_chg ##[1:1000] result_ready);

endmodule

// File: verif/adc_trigger_model.sv
`timescale 1ns/1ps
// Far side: trigger logic that pulses start-of-conversion like a divided clock, and the decimator word
module adc_trigger_model #(
    parameter int GAP   = 6,
    parameter int RES_W = 16
) (
    input  wire logic             sys_clk_i,
    input  wire logic             en_i,
    input  wire logic [RES_W-1:0] word_i,
    output logic                  soc_o,
    output logic      [RES_W-1:0] dec_data_o
);
    int cnt;

    always_ff @(posedge sys_clk_i) begin
        if (!en_i || cnt == GAP - 1) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // Two-cycle pulse every GAP cycles while enabled, low otherwise
    assign soc_o      = en_i && (cnt < 2);
    assign dec_data_o = word_i;
endmodule

// File: verif/tb_adc_conversion_sequencer.sv
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
    localparam int P  = 2;
    localparam int PC = 8;

    logic                           sys_clk_i = 1'b0;
    logic                           srst_i    = 1'b1;
    logic [adc_seq_pkg::ADDR_W-1:0] addr_i    = 8'h00;
    logic [adc_seq_pkg::DATA_W-1:0] wdata_i   = 32'h0000_0000;
    logic                           wr_i      = 1'b0;
    logic                           rd_i      = 1'b0;
    logic                           trg_en    = 1'b0;
    logic [15:0]                    word      = 16'h0000;
    logic [adc_seq_pkg::DATA_W-1:0] rdata_o;
    logic [15:0]                    dec_data;
    logic [3:0]                     mux_sel_o;
    logic                           soc;
    logic                           mod_run_o;
    logic                           decim_clr_o;
    logic                           eoc_o;
    logic                           irq_o;
    logic [31:0]                    v;
    int                             err_total = 0;
    int                             compares  = 0;
    int                             clr_cnt   = 0;
    int                             k;
    int                             s;

    adc_conversion_sequencer dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .soc_i(soc), .dec_data_i(dec_data), .mod_run_o(mod_run_o),
        .decim_clr_o(decim_clr_o), .mux_sel_o(mux_sel_o), .eoc_o(eoc_o), .irq_o(irq_o)
    );

    adc_trigger_model far (
        .sys_clk_i(sys_clk_i), .en_i(trg_en), .word_i(word), .soc_o(soc), .dec_data_o(dec_data)
    );

    always #5 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i) begin
        if (decim_clr_o === 1'b1) begin
            clr_cnt <= clr_cnt + 1;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task inrange(input int n, input int lo, input int hi);
        chk({31'h0000_0000, (n >= lo) && (n <= hi)}, 32'h0000_0001);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        d = rdata_o;
    endtask

    task wait_eoc(output int n);
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (eoc_o !== 1'b1 && n < 400);
    endtask

    task finish_test;
        $display("comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        // Register map basics
        rd(adc_seq_pkg::REG_PERIOD, v);
        chk(v, 32'h0000_01f4);
        wr(adc_seq_pkg::REG_MUXSEL, 32'h0000_0003);
        rd(adc_seq_pkg::REG_MUXSEL, v);
        chk(v, 32'h0000_0003);
        chk({28'h000_0000, mux_sel_o}, 32'h0000_0003);
        rd(8'h1c, v);
        chk(v, 32'h0000_0000);
        wr(adc_seq_pkg::REG_PERIOD, P);
        $display("test registers done");
        // Single sample from the software start bit, with interrupt handling
        word <= 16'ha5c3;
        wr(adc_seq_pkg::REG_IRQ_STAT, 32'h0000_0003);
        wr(adc_seq_pkg::REG_CTRL, 32'h0000_0001);
        wait_eoc(k);
        chk(k, 4 * P + 1);
        chk(mod_run_o, 1'b0);
        chk(irq_o, 1'b0);
        wr(adc_seq_pkg::REG_IRQ_MASK, 32'h0000_0001);
        @(negedge sys_clk_i);
        chk(irq_o, 1'b1);
        wr(adc_seq_pkg::REG_IRQ_STAT, 32'h0000_0001);
        @(negedge sys_clk_i);
        chk(irq_o, 1'b0);
        rd(adc_seq_pkg::REG_STATUS, v);
        chk(v[adc_seq_pkg::STAT_DONE_BIT], 1'b1);
        chk(v[adc_seq_pkg::STAT_HOLD_BIT], 1'b1);
        chk(eoc_o, 1'b1);
        rd(adc_seq_pkg::REG_RESULT, v);
        chk(v, 32'h0000_a5c3);
        chk(eoc_o, 1'b0);
        repeat (8 * P) @(negedge sys_clk_i);
        chk({eoc_o, mod_run_o}, 2'b00);
        rd(adc_seq_pkg::REG_STATUS, v);
        chk(v[adc_seq_pkg::STAT_BUSY_BIT], 1'b0);
        chk(v[adc_seq_pkg::STAT_HOLD_BIT], 1'b0);
        $display("test single software done");
        // Single sample from the start pin; a second pulse lands mid-run
        word <= 16'h3c5a;
        @(posedge sys_clk_i);
        trg_en <= 1'b1;
        wait_eoc(k);
        inrange(k, 4 * P + 2, 4 * P + 5);
        @(posedge sys_clk_i);
        trg_en <= 1'b0;
        rd(adc_seq_pkg::REG_RESULT, v);
        chk(v, 32'h0000_3c5a);
        $display("test single pin done");
        // Continuous mode with the pin idle, then an overrun and a stop
        wr(adc_seq_pkg::REG_PERIOD, PC);
        word <= 16'h1111;
        wr(adc_seq_pkg::REG_CTRL, 32'h0000_0005);
        wait_eoc(k);
        chk(k, 4 * PC + 1);
        s = clr_cnt;
        word <= 16'h2222;
        rd(adc_seq_pkg::REG_RESULT, v);
        chk(v, 32'h0000_1111);
        wait_eoc(k);
        chk(k, PC - 2);
        chk(clr_cnt - s, 0);
        rd(adc_seq_pkg::REG_RESULT, v);
        chk(v, 32'h0000_2222);
        repeat (2 * PC) @(negedge sys_clk_i);
        chk({28'h000_0000, mux_sel_o}, 32'h0000_0003);
        rd(adc_seq_pkg::REG_IRQ_STAT, v);
        chk(v[adc_seq_pkg::IRQ_OVR_BIT], 1'b1);
        wr(adc_seq_pkg::REG_CTRL, 32'h0000_0002);
        rd(adc_seq_pkg::REG_RESULT, v);
        chk(v, 32'h0000_2222);
        chk(mod_run_o, 1'b0);
        $display("test continuous done");
        // Multi-sample mode: clear and re-prime between results, no new trigger
        word <= 16'h4444;
        wr(adc_seq_pkg::REG_CTRL, 32'h0000_0009);
        wait_eoc(k);
        chk(k, 4 * PC + 1);
        s = clr_cnt;
        word <= 16'h5555;
        rd(adc_seq_pkg::REG_RESULT, v);
        chk(v, 32'h0000_4444);
        wait_eoc(k);
        inrange(k, 4 * PC - 2, 4 * PC);
        chk(clr_cnt - s, 1);
        rd(adc_seq_pkg::REG_RESULT, v);
        chk(v, 32'h0000_5555);
        wr(adc_seq_pkg::REG_MUXSEL, 32'h0000_0005);
        @(negedge sys_clk_i);
        chk({28'h000_0000, mux_sel_o}, 32'h0000_0005);
        wait_eoc(k);
        inrange(k, 3 * PC, 4 * PC + 2);
        wr(adc_seq_pkg::REG_CTRL, 32'h0000_0002);
        $display("test multi done");
        finish_test();
    end
endmodule
